/* verilog/rics_top.sv */
// Radio interrupt enable set/clear, event status and packet check result with APB access
`timescale 1ns/100ps

module rics_top
  import rics_pkg::*;
(
  // Clock and reset
  input  wire logic                       core_clk_in,
  input  wire logic                       reset_n_in,
  // APB slave
  input  wire logic                       psel_in,
  input  wire logic                       penable_in,
  input  wire logic                       pwrite_in,
  input  wire logic [11:0]                paddr_in,
  input  wire logic [31:0]                pwdata_in,
  output logic      [31:0]                prdata_out,
  output logic                            pready_out,
  output logic                            pslverr_out,
  // Radio core events, one-cycle pulses
  input  wire logic [RICS_NUM_RAW-1:0]    raw_event_in,
  input  wire logic                       strength_valid_in,
  input  wire logic [RICS_STRENGTH_W-1:0] strength_value_in,
  input  wire logic                       bit_count_valid_in,
  input  wire logic [RICS_BC_W-1:0]       bit_count_in,
  input  wire logic                       check_done_in,
  input  wire logic                       check_ok_in,
  // Interrupt
  output logic                            irq_out
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  wire logic rst_n = rst_sync_r;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  logic [RICS_NUM_EVT-1:0]    enable_r;
  logic [RICS_NUM_EVT-1:0]    enable_nxt;
  logic [RICS_NUM_EVT-1:0]    status_r;
  logic [RICS_NUM_EVT-1:0]    status_nxt;
  logic                       check_r;
  logic                       check_nxt;
  logic [RICS_BC_W-1:0]       bc_cmp_r;
  logic [RICS_BC_W-1:0]       bc_cmp_nxt;
  logic [RICS_STRENGTH_W-1:0] strength_r;
  logic [RICS_STRENGTH_W-1:0] strength_nxt;
  logic                       irq_r;
  logic                       irq_nxt;

  logic setup;
  logic commit;
  logic wr_commit;
  logic mapped;

  assign setup     = psel_in && !penable_in;
  // Writes land only at the edge where the access completes
  assign commit    = psel_in && penable_in && pready_r;
  assign wr_commit = commit && pwrite_in;

  always_comb begin
    case (paddr_in)
      RICS_OFF_EVT_STATUS,
      RICS_OFF_BC_COMPARE,
      RICS_OFF_STRENGTH,
      RICS_OFF_IRQ_SET,
      RICS_OFF_IRQ_CLEAR,
      RICS_OFF_CHECK_RES: mapped = 1'b1;
      default:            mapped = 1'b0;
    endcase
  end

  // Read data is captured in setup so that the access phase is always one cycle
  always_comb begin
    pready_nxt  = setup;
    pslverr_nxt = setup && !mapped;
    prdata_nxt  = 32'h0000_0000;
    if (setup && !pwrite_in) begin
      case (paddr_in)
        RICS_OFF_EVT_STATUS: prdata_nxt = rics_spread(status_r);
        RICS_OFF_BC_COMPARE: prdata_nxt = {{(32-RICS_BC_W){1'b0}}, bc_cmp_r};
        RICS_OFF_STRENGTH:   prdata_nxt = {{(32-RICS_STRENGTH_W){1'b0}}, strength_r};
        RICS_OFF_IRQ_SET:    prdata_nxt = rics_spread(enable_r);
        RICS_OFF_IRQ_CLEAR:  prdata_nxt = rics_spread(enable_r);
        RICS_OFF_CHECK_RES:  prdata_nxt = {31'h0000_0000, check_r};
        default:             prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt enable state
  // ----------------------------------------------------------------
  logic [RICS_NUM_EVT-1:0] wr_bits;

  assign wr_bits = rics_gather(pwdata_in);

  // Set and clear share one enable state; zeros in either write leave bits alone
  always_comb begin
    enable_nxt = enable_r;
    if (wr_commit && paddr_in == RICS_OFF_IRQ_SET) begin
      enable_nxt = enable_r | wr_bits;
    end else if (wr_commit && paddr_in == RICS_OFF_IRQ_CLEAR) begin
      enable_nxt = enable_r & ~wr_bits;
    end
  end

  // ----------------------------------------------------------------
  // Radio events and captured values
  // ----------------------------------------------------------------
  logic [RICS_NUM_EVT-1:0] evt;
  logic                    bc_hit;

  // Compare is an equality against the core's running count, so a compare of zero fires on a valid count of zero
  assign bc_hit = bit_count_valid_in && (bit_count_in == bc_cmp_r);

  always_comb begin
    evt                    = '0;
    evt[RICS_NUM_RAW-1:0]  = raw_event_in;
    evt[RICS_EV_STRENGTH]  = strength_valid_in;
    evt[RICS_EV_BIT_COUNT] = bc_hit;
    evt[RICS_EV_PASS]      = check_done_in && check_ok_in;
    evt[RICS_EV_FAIL]      = check_done_in && !check_ok_in;
  end

  // Sticky status: an event in the cycle of its write-one clear survives
  always_comb begin
    status_nxt = status_r;
    if (wr_commit && paddr_in == RICS_OFF_EVT_STATUS) begin
      status_nxt = status_nxt & ~wr_bits;
    end
    status_nxt = status_nxt | evt;
  end

  always_comb begin
    check_nxt = check_r;
    if (check_done_in) begin
      check_nxt = check_ok_in;
    end
  end

  always_comb begin
    bc_cmp_nxt = bc_cmp_r;
    if (wr_commit && paddr_in == RICS_OFF_BC_COMPARE) begin
      bc_cmp_nxt = pwdata_in[RICS_BC_W-1:0];
    end
  end

  always_comb begin
    strength_nxt = strength_r;
    if (strength_valid_in) begin
      strength_nxt = strength_value_in;
    end
  end

  // Each event reaches the line only through its own enable bit
  always_comb begin
    irq_nxt = |(status_nxt & enable_nxt);
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      enable_r   <= RICS_EN_RST;
      status_r   <= RICS_STATUS_RST;
      check_r    <= RICS_CHECK_RST;
      bc_cmp_r   <= RICS_BC_RST;
      strength_r <= RICS_STRENGTH_RST;
      irq_r      <= 1'b0;
    end else begin
      enable_r   <= enable_nxt;
      status_r   <= status_nxt;
      check_r    <= check_nxt;
      bc_cmp_r   <= bc_cmp_nxt;
      strength_r <= strength_nxt;
      irq_r      <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata_out  = prdata_r;
  assign pready_out  = pready_r;
  assign pslverr_out = pslverr_r;
  assign irq_out     = irq_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_clear_disables: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (wr_commit && paddr_in == RICS_OFF_IRQ_CLEAR)
      |=> enable_r == ($past(enable_r) & ~$past(wr_bits)))
    else $error("clear write did not disable exactly the written events");

  a_field_ready: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (setup && !pwrite_in && paddr_in == RICS_OFF_EVT_STATUS)
      |=> prdata_out[0] == $past(status_r[RICS_EV_READY]) && prdata_out[13] == $past(status_r[RICS_EV_FAIL]))
    else $error("event fields not at their register bits");

  a_strength_event: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    strength_valid_in |=> status_r[RICS_EV_STRENGTH] && strength_r == $past(strength_value_in))
    else $error("strength sample event or value lost");

  a_bit_count_hit: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (bit_count_valid_in && bit_count_in == bc_cmp_r) |=> status_r[RICS_EV_BIT_COUNT])
    else $error("bit count hit event not raised");

  a_pass_fail_mask: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (check_done_in && !check_ok_in && !enable_r[RICS_EV_FAIL] && status_r == '0
      && !wr_commit && evt == (1 << RICS_EV_FAIL))
      |=> status_r[RICS_EV_FAIL] && !status_r[RICS_EV_PASS] ##1 !irq_out)
    else $error("masked check fail reached the interrupt line");

  a_check_result: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    check_done_in |=> check_r == $past(check_ok_in)
      && (status_r[RICS_EV_PASS] || !$past(check_ok_in))
      && (status_r[RICS_EV_FAIL] || $past(check_ok_in)))
    else $error("check status bit disagrees with last packet");

  a_set_enables: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (wr_commit && paddr_in == RICS_OFF_IRQ_SET) |=> enable_r == ($past(enable_r) | $past(wr_bits)))
    else $error("set write did not enable the written events");

  a_clear_readback: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (setup && !pwrite_in && paddr_in == RICS_OFF_IRQ_CLEAR)
      |=> pready_out && !pslverr_out && prdata_out == rics_spread($past(enable_r)))
    else $error("clear register read does not show enable state");

  a_zero_write_noop: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (wr_commit && paddr_in == RICS_OFF_IRQ_CLEAR && wr_bits == '0) |=> $stable(enable_r))
    else $error("zero write changed the enable state");

  // An event landing in the cycle of its own clear must not be lost
  a_event_beats_clear: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (wr_commit && paddr_in == RICS_OFF_EVT_STATUS && raw_event_in[RICS_EV_READY])
      |=> status_r[RICS_EV_READY])
    else $error("event lost against its own status clear");

  a_ro_write_ignored: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (wr_commit && paddr_in == RICS_OFF_CHECK_RES && !check_done_in) |=> $stable(check_r))
    else $error("write changed the read-only check status");

  a_irq_level: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    irq_out == |(status_r & enable_r))
    else $error("interrupt line disagrees with enabled status bits");

  a_unmapped_err: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (setup && !mapped) |=> pready_out && pslverr_out && prdata_out == 32'h0000_0000)
    else $error("unmapped access not answered with an error");

  a_pready_single: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    pready_out |=> !pready_out)
    else $error("ready held for more than one cycle");

endmodule

/* verilog/rics_pkg.sv */
// Package of register map, field positions and reset values for the radio interrupt block
package rics_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] RICS_OFF_EVT_STATUS  = 12'h100;
  localparam logic [11:0] RICS_OFF_BC_COMPARE  = 12'h104;
  localparam logic [11:0] RICS_OFF_STRENGTH    = 12'h108;
  localparam logic [11:0] RICS_OFF_IRQ_SET     = 12'h304;
  localparam logic [11:0] RICS_OFF_IRQ_CLEAR   = 12'h308;
  localparam logic [11:0] RICS_OFF_CHECK_RES   = 12'h400;

  // ----------------------------------------------------------------
  // Event fields, A through K
  // ----------------------------------------------------------------
  localparam int RICS_NUM_EVT = 11;
  localparam int RICS_NUM_RAW = 7;

  localparam int RICS_EV_READY     = 0;
  localparam int RICS_EV_ADDRESS   = 1;
  localparam int RICS_EV_PAYLOAD   = 2;
  localparam int RICS_EV_END       = 3;
  localparam int RICS_EV_DISABLED  = 4;
  localparam int RICS_EV_DEV_MATCH = 5;
  localparam int RICS_EV_DEV_MISS  = 6;
  localparam int RICS_EV_STRENGTH  = 7;
  localparam int RICS_EV_BIT_COUNT = 8;
  localparam int RICS_EV_PASS      = 9;
  localparam int RICS_EV_FAIL      = 10;

  // Bit position of each event field within a 32-bit register word
  localparam int RICS_EVT_POS [RICS_NUM_EVT] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 12, 13};

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int RICS_BC_W       = 16;
  localparam int RICS_STRENGTH_W = 7;

  localparam logic [RICS_NUM_EVT-1:0]    RICS_EN_RST       = 11'h000;
  localparam logic [RICS_NUM_EVT-1:0]    RICS_STATUS_RST   = 11'h000;
  localparam logic                       RICS_CHECK_RST    = 1'h0;
  localparam logic [RICS_BC_W-1:0]       RICS_BC_RST       = 16'h0000;
  localparam logic [RICS_STRENGTH_W-1:0] RICS_STRENGTH_RST = 7'h00;

  // Spread an event vector onto its register bit positions
  function automatic logic [31:0] rics_spread(input logic [RICS_NUM_EVT-1:0] v);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int i = 0; i < RICS_NUM_EVT; i++) begin
      w[RICS_EVT_POS[i]] = v[i];
    end
    return w;
  endfunction

  // Gather an event vector from its register bit positions
  function automatic logic [RICS_NUM_EVT-1:0] rics_gather(input logic [31:0] w);
    logic [RICS_NUM_EVT-1:0] v;
    v = '0;
    for (int i = 0; i < RICS_NUM_EVT; i++) begin
      v[i] = w[RICS_EVT_POS[i]];
    end
    return v;
  endfunction

endpackage

/* dv/tb_rics_top.sv */
// Testbench for the radio interrupt enable, event status and packet check block
`timescale 1ns/100ps

module tb_rics_top
  import rics_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [31:0] ALL = 32'h0000_34ff;
  localparam int          POS [11] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 12, 13};

  logic                       clk;
  logic                       rst_n;
  logic                       psel;
  logic                       penable;
  logic                       pwrite;
  logic [11:0]                paddr;
  logic [31:0]                pwdata;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  logic [RICS_NUM_RAW-1:0]    raw_ev;
  logic                       str_v;
  logic [RICS_STRENGTH_W-1:0] str_val;
  logic                       bc_v;
  logic [RICS_BC_W-1:0]       bc_val;
  logic                       chk_done;
  logic                       chk_ok;
  logic                       irq;
  logic [31:0]                exp;
  logic [31:0]                rd;
  logic                       err;
  int                         errors;
  int                         tests_run;

  rics_top dut (
    .core_clk_in        (clk),
    .reset_n_in         (rst_n),
    .psel_in            (psel),
    .penable_in         (penable),
    .pwrite_in          (pwrite),
    .paddr_in           (paddr),
    .pwdata_in          (pwdata),
    .prdata_out         (prdata),
    .pready_out         (pready),
    .pslverr_out        (pslverr),
    .raw_event_in       (raw_ev),
    .strength_valid_in  (str_v),
    .strength_value_in  (str_val),
    .bit_count_valid_in (bc_v),
    .bit_count_in       (bc_val),
    .check_done_in      (chk_done),
    .check_ok_in        (chk_ok),
    .irq_out            (irq)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk32(input string name, input logic [31:0] e, input logic [31:0] got);
    tests_run++;
    if (got !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, e, got);
    end
  endtask

  task automatic chk1(input string name, input logic e, input logic got);
    tests_run++;
    if (got !== e) begin
      errors++;
      $display("unexpected %s: expected %b, seen %b", name, e, got);
    end
  endtask

  // Holds the request until pready is sampled high; a bounded wait guards a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      $display("unexpected pready: expected 1, seen %b", pready);
      stop_test();
    end else begin
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string name);
    apb(1'b0, a, 32'h0000_0000);
    chk32(name, e, rd);
  endtask

  task automatic pulse(input logic [RICS_NUM_RAW-1:0] raw, input logic sv, input logic bv, input logic cd);
    @(posedge clk);
    raw_ev   <= raw;
    str_v    <= sv;
    bc_v     <= bv;
    chk_done <= cd;
    @(posedge clk);
    raw_ev   <= '0;
    str_v    <= 1'b0;
    bc_v     <= 1'b0;
    chk_done <= 1'b0;
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Clock, reset and sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    {rst_n, psel, penable, pwrite, str_v, bc_v, chk_done, chk_ok} = '0;
    {paddr, pwdata, raw_ev, str_val, bc_val} = '0;
    errors = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk1("irq_rst", 1'b0, irq);
    rd_chk(RICS_OFF_IRQ_CLEAR, 32'h0, "clear_rst");
    rd_chk(RICS_OFF_CHECK_RES, 32'h0, "check_rst");
    chk1("mapped_err", 1'b0, err);
    apb(1'b1, RICS_OFF_IRQ_SET, 32'hffff_ffff);
    rd_chk(RICS_OFF_IRQ_SET, ALL, "set_read");
    rd_chk(RICS_OFF_IRQ_CLEAR, ALL, "enable_all");
    apb(1'b1, RICS_OFF_IRQ_CLEAR, 32'h0);
    rd_chk(RICS_OFF_IRQ_CLEAR, ALL, "zero_write");
    // Drop one enable at a time; the others must survive
    exp = ALL;
    for (int i = 0; i < 11; i++) begin
      exp[POS[i]] = 1'b0;
      apb(1'b1, RICS_OFF_IRQ_CLEAR, 32'h1 << POS[i]);
      rd_chk(RICS_OFF_IRQ_CLEAR, exp, "clear_one");
    end
    apb(1'b1, RICS_OFF_IRQ_SET, ALL);
    for (int i = 0; i < RICS_NUM_RAW; i++) begin
      pulse(RICS_NUM_RAW'(1 << i), 1'b0, 1'b0, 1'b0);
      chk1("irq_raw", 1'b1, irq);
      rd_chk(RICS_OFF_EVT_STATUS, 32'h1 << POS[i], "raw_status");
      apb(1'b1, RICS_OFF_EVT_STATUS, 32'hffff_ffff);
      @(posedge clk);
      chk1("irq_cleared", 1'b0, irq);
    end
    // A ready event in the very cycle of its write-one clear must survive
    fork
      apb(1'b1, RICS_OFF_EVT_STATUS, 32'hffff_ffff);
      begin
        repeat (2) @(posedge clk);
        raw_ev <= 7'h01;
        @(posedge clk);
        raw_ev <= 7'h00;
      end
    join
    rd_chk(RICS_OFF_EVT_STATUS, 32'h1, "evt_wins");
    apb(1'b1, RICS_OFF_EVT_STATUS, 32'hffff_ffff);
    str_val <= 7'h5a;
    pulse('0, 1'b1, 1'b0, 1'b0);
    chk1("irq_strength", 1'b1, irq);
    rd_chk(RICS_OFF_STRENGTH, 32'h5a, "strength_val");
    rd_chk(RICS_OFF_EVT_STATUS, 32'h80, "strength_evt");
    apb(1'b1, RICS_OFF_EVT_STATUS, 32'hffff_ffff);
    apb(1'b1, RICS_OFF_BC_COMPARE, 32'h0000_0123);
    rd_chk(RICS_OFF_BC_COMPARE, 32'h0000_0123, "bc_cmp");
    bc_val <= 16'h0122;
    pulse('0, 1'b0, 1'b1, 1'b0);
    rd_chk(RICS_OFF_EVT_STATUS, 32'h0, "bc_below");
    bc_val <= 16'h0123;
    pulse('0, 1'b0, 1'b1, 1'b0);
    rd_chk(RICS_OFF_EVT_STATUS, 32'h400, "bc_hit");
    apb(1'b1, RICS_OFF_EVT_STATUS, 32'hffff_ffff);
    // Only the pass event is unmasked, so a fail must stay silent
    apb(1'b1, RICS_OFF_IRQ_CLEAR, ALL);
    apb(1'b1, RICS_OFF_IRQ_SET, 32'h1000);
    chk_ok <= 1'b1;
    pulse('0, 1'b0, 1'b0, 1'b1);
    chk1("irq_pass", 1'b1, irq);
    rd_chk(RICS_OFF_CHECK_RES, 32'h1, "check_ok");
    apb(1'b1, RICS_OFF_CHECK_RES, 32'h0);
    rd_chk(RICS_OFF_CHECK_RES, 32'h1, "check_ro");
    apb(1'b1, RICS_OFF_EVT_STATUS, 32'hffff_ffff);
    chk_ok <= 1'b0;
    pulse('0, 1'b0, 1'b0, 1'b1);
    chk1("irq_fail_masked", 1'b0, irq);
    rd_chk(RICS_OFF_EVT_STATUS, 32'h2000, "fail_evt");
    rd_chk(RICS_OFF_CHECK_RES, 32'h0, "check_err");
    apb(1'b1, RICS_OFF_IRQ_SET, 32'h2000);
    @(posedge clk);
    chk1("irq_fail_open", 1'b1, irq);
    apb(1'b0, 12'hffc, 32'h0);
    chk1("unmapped_err", 1'b1, err);
    chk32("unmapped_data", 32'h0, rd);
    stop_test();
  end

endmodule
